// >>> pkg/sepc_cfg.svh
/*
 * constants for the serial eeprom command and protection block:
 * opcodes, status bit positions, page and array geometry, write timing.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef SEPC_CFG_SVH
`define SEPC_CFG_SVH

`define SEPC_OP_SET_WEL   8'h06
`define SEPC_OP_CLR_WEL   8'h04
`define SEPC_OP_RD_STAT   8'h05
`define SEPC_OP_WR_STAT   8'h01
`define SEPC_OP_RD_MEM    8'h03
`define SEPC_OP_WR_MEM    8'h02

`define SEPC_SR_BUSY      0
`define SEPC_SR_WEL       1
`define SEPC_SR_BG_LO     2
`define SEPC_SR_BG_HI     3
`define SEPC_SR_PPE       7

`define SEPC_ADDR_W       11
`define SEPC_ADDR_W8K     10
`define SEPC_PAGE_W       5
`define SEPC_MEM_DEPTH    2048
`define SEPC_ADDR_BITS    16

// internal write cycle time in microseconds, clock period in ns
`define SEPC_TWC_US       5000
`define SEPC_CLK_NS       5

`endif

// >>> pkg/sepc_pkg.sv
/*
 * types shared by the serial eeprom command block and its helpers.
 * assumes sepc_cfg.svh is on the include path.
 */
`include "sepc_cfg.svh"
package sepc_pkg;
    typedef enum logic [2:0] {
        SEPC_OPCODE,
        SEPC_ADDR,
        SEPC_DATA,
        SEPC_STAT_DATA,
        SEPC_SHIFT_OUT,
        SEPC_IGNORE
    } sepc_phase_t;
endpackage

// >>> pkg/sepc_mem_if.sv
/*
 * memory port bundle between the command block and the array.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sepc_cfg.svh"
interface sepc_mem_if;
    logic                     we;
    logic [`SEPC_ADDR_W-1:0]  waddr;
    logic [7:0]               wdata;
    logic [`SEPC_ADDR_W-1:0]  raddr;
    logic [7:0]               rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface
`default_nettype wire

// >>> design/sepc_sync.sv
/*
 * two flip-flop synchroniser for one pin.
 * assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sepc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    output logic      sync_o
);
    logic meta_ff;
    logic sync_ff;
    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule
`default_nettype wire

// >>> design/sepc_mem.sv
/*
 * byte array with one write port and one registered read port.
 * assumes page buffer commits one byte per clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sepc_cfg.svh"
module sepc_mem (
    input  wire logic clk_i,
    sepc_mem_if.mem   mif
);
    logic [7:0] mem_q [0:`SEPC_MEM_DEPTH-1];
    logic [7:0] rdata_ff;
    // no reset on the array: contents are non-volatile in spirit
    always_ff @(posedge clk_i) begin
        if (mif.we) begin
            mem_q[mif.waddr] <= mif.wdata;
        end
        rdata_ff <= mem_q[mif.raddr];
    end
    assign mif.rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> design/sepc_top.sv
/*
 * device-side command and protection logic of a small spi eeprom:
 * opcode decode, write latch, status register, block protection,
 * page load with wrap, self-timed write cycle.
 * assumes spi pins are asynchronous; spi clock is oversampled by clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sepc_cfg.svh"
module sepc_top import sepc_pkg::*; #(
    parameter int  TWC_CYC  = (`SEPC_TWC_US * 1000) / `SEPC_CLK_NS,
    parameter logic BIG_ARR = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic spi_clock_i,
    input  wire logic select_n_i,
    input  wire logic serial_in_i,
    input  wire logic pause_n_i,
    input  wire logic write_protect_n_i,
    output logic      serial_out_o,
    output logic      serial_out_oe_o,
    output logic      busy_o
);
    // every check below runs on the system clock, off during reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic sck_s, cs_n_s, si_s, hold_n_s, wp_n_s;
    sepc_sync u_s_sck (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .pin_i(spi_clock_i), .sync_o(sck_s));
    sepc_sync #(.RST_VAL(1'b1)) u_s_cs (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .pin_i(select_n_i), .sync_o(cs_n_s));
    sepc_sync u_s_si (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .pin_i(serial_in_i), .sync_o(si_s));
    sepc_sync #(.RST_VAL(1'b1)) u_s_hd (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .pin_i(pause_n_i), .sync_o(hold_n_s));
    sepc_sync #(.RST_VAL(1'b1)) u_s_wp (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .pin_i(write_protect_n_i), .sync_o(wp_n_s));

    sepc_mem_if mif ();
    sepc_mem u_mem (.clk_i(clk_i), .mif(mif));

    // state
    logic                    sck_d_ff, cs_d_ff, hold_ff, nxt_hold, hold_d_ff;
    sepc_phase_t             ph_ff, nxt_ph;
    logic [7:0]              sh_ff, nxt_sh, op_ff, nxt_op;
    logic [3:0]              bcnt_ff, nxt_bcnt;
    logic [4:0]              acnt_ff, nxt_acnt;
    logic [`SEPC_ADDR_BITS-1:0] adr_ff, nxt_adr;
    logic [7:0]              page_ff [0:31];
    logic [31:0]             pval_ff, nxt_pval;
    logic [5:0]              ndat_ff, nxt_ndat;
    logic                    wel_ff, nxt_wel, ppe_ff, nxt_ppe;
    logic [1:0]              bg_ff, nxt_bg;
    logic [7:0]              sd_ff, nxt_sd;
    logic                    sabort_ff, nxt_sabort;
    logic                    busy_ff, nxt_busy, wmem_ff, nxt_wmem;
    logic [31:0]             tmr_ff, nxt_tmr;
    logic [5:0]              cidx_ff, nxt_cidx;
    logic [7:0]              osh_ff, nxt_osh;
    logic                    so_ff, nxt_so, oe_ff, nxt_oe;
    logic                    pg_we;
    logic [4:0]              pg_idx;

    wire sck_rise = sck_s & ~sck_d_ff & ~cs_n_s & ~hold_ff;
    wire sck_fall = ~sck_s & sck_d_ff & ~cs_n_s & ~hold_ff;
    wire cs_fall  = ~cs_n_s & cs_d_ff;
    wire cs_rise  = cs_n_s & ~cs_d_ff;
    wire [7:0] sh_in = {sh_ff[6:0], si_s};
    wire [7:0] stat = {ppe_ff, 3'b000, bg_ff, wel_ff, busy_ff};
    wire [`SEPC_ADDR_W-1:0] amask = BIG_ARR ? 11'h7ff : 11'h3ff;
    wire [`SEPC_ADDR_W-1:0] wa = adr_ff[`SEPC_ADDR_W-1:0] & amask;

    // block guard check on an 11-bit masked address
    function automatic logic guarded(input logic [`SEPC_ADDR_W-1:0] a,
                                     input logic [1:0] g,
                                     input logic big);
        guarded = 1'b0;
        unique case (g)
            2'b00: guarded = 1'b0;
            2'b01: guarded = big ? (a[10:9] == 2'b11)
                                 : (a[9:8] == 2'b11);
            2'b10: guarded = big ? a[10] : a[9];
            2'b11: guarded = 1'b1;
        endcase
    endfunction

    // page buffer: one byte per loaded data word, index wraps in page
    assign pg_idx = acnt_ff;
    always_ff @(posedge clk_i) begin
        if (pg_we) begin
            page_ff[pg_idx] <= sh_in;
        end
    end

    // memory port: commit one page byte per clock during write cycle
    wire [`SEPC_ADDR_W-1:0] cad = {wa[10:5], cidx_ff[4:0]};
    assign mif.we    = busy_ff & wmem_ff & ~cidx_ff[5] & pval_ff[cidx_ff[4:0]]
                       & ~guarded(cad, bg_ff, BIG_ARR);
    assign mif.waddr = cad;
    assign mif.wdata = page_ff[cidx_ff[4:0]];
    assign mif.raddr = wa;

    // session, shift and protection next-state
    always_comb begin
        nxt_hold = hold_ff; nxt_ph = ph_ff; nxt_sh = sh_ff; nxt_op = op_ff;
        nxt_bcnt = bcnt_ff; nxt_acnt = acnt_ff; nxt_adr = adr_ff;
        nxt_pval = pval_ff; nxt_ndat = ndat_ff; nxt_wel = wel_ff;
        nxt_ppe = ppe_ff; nxt_bg = bg_ff; nxt_sd = sd_ff;
        nxt_sabort = sabort_ff; nxt_busy = busy_ff; nxt_wmem = wmem_ff;
        nxt_tmr = tmr_ff; nxt_cidx = cidx_ff; nxt_osh = osh_ff;
        nxt_so = so_ff; nxt_oe = oe_ff; pg_we = 1'b0;
        // pause only changes while spi clock is low
        if (~sck_s) nxt_hold = ~hold_n_s & ~cs_n_s;
        if (cs_fall) begin
            nxt_ph = SEPC_OPCODE; nxt_bcnt = 4'h0;
            nxt_sabort = 1'b0; nxt_ndat = 6'h00; nxt_oe = 1'b0;
        end
        if (~cs_n_s & ~wp_n_s & ppe_ff) nxt_sabort = 1'b1;
        if (sck_rise && ph_ff != SEPC_IGNORE) begin
            nxt_sh = sh_in;
            nxt_bcnt = (bcnt_ff == 4'h7) ? 4'h0 : bcnt_ff + 4'h1;
            if (ph_ff == SEPC_ADDR) nxt_adr = {adr_ff[14:0], si_s};
            if (bcnt_ff == 4'h7) begin
                unique case (ph_ff)
                    SEPC_OPCODE: begin
                        nxt_op = sh_in;
                        nxt_ph = SEPC_IGNORE;
                        if (sh_in == `SEPC_OP_RD_STAT) begin
                            nxt_ph = SEPC_SHIFT_OUT; nxt_osh = stat;
                        end else if (!busy_ff) begin
                            unique case (sh_in)
                                `SEPC_OP_SET_WEL: nxt_ph = SEPC_IGNORE;
                                `SEPC_OP_CLR_WEL: nxt_ph = SEPC_IGNORE;
                                `SEPC_OP_WR_STAT: nxt_ph = SEPC_STAT_DATA;
                                `SEPC_OP_RD_MEM,
                                `SEPC_OP_WR_MEM: begin
                                    nxt_ph = SEPC_ADDR; nxt_acnt = 5'h00;
                                end
                                default: nxt_ph = SEPC_IGNORE;
                            endcase
                        end
                        if (busy_ff && sh_in != `SEPC_OP_RD_STAT)
                            nxt_op = 8'h00;
                    end
                    SEPC_ADDR: begin
                        nxt_acnt = acnt_ff + 5'h01;
                        if (acnt_ff == 5'h01) begin
                            nxt_pval = 32'h0000_0000;
                            nxt_acnt = {sh_in[4:0]};
                            if (op_ff == `SEPC_OP_RD_MEM) begin
                                nxt_ph = SEPC_SHIFT_OUT;
                            end else begin
                                nxt_ph = SEPC_DATA;
                            end
                        end
                    end
                    SEPC_DATA: begin
                        pg_we = 1'b1;
                        nxt_pval[acnt_ff] = 1'b1;
                        nxt_acnt = acnt_ff + 5'h01;
                        nxt_ndat = (ndat_ff == 6'h3f) ? ndat_ff
                                   : ndat_ff + 6'h01;
                    end
                    SEPC_STAT_DATA: begin
                        nxt_sd = sh_in; nxt_ndat = 6'h01;
                        nxt_ph = SEPC_IGNORE;
                    end
                    default: nxt_ph = ph_ff;
                endcase
            end
        end
        // output shifter: status repeats; memory reads stream on
        if (sck_fall && ph_ff == SEPC_SHIFT_OUT) begin
            nxt_oe = 1'b1;
            nxt_so = osh_ff[7];
            nxt_osh = {osh_ff[6:0], 1'b0};
            if (bcnt_ff == 4'h0) begin
                nxt_so = (op_ff == `SEPC_OP_RD_MEM) ? mif.rdata[7] : stat[7];
                nxt_osh = (op_ff == `SEPC_OP_RD_MEM) ? {mif.rdata[6:0], 1'b0}
                                                     : {stat[6:0], 1'b0};
                if (op_ff == `SEPC_OP_RD_MEM)
                    nxt_adr = adr_ff + 16'h0001;
            end
        end
        if (cs_n_s | hold_ff) nxt_oe = 1'b0;
        // a resumed read drives again without waiting for the next fall
        if (hold_d_ff && !hold_ff && !cs_n_s && ph_ff == SEPC_SHIFT_OUT)
            nxt_oe = 1'b1;
        // session end at whole byte boundary
        if (cs_rise && bcnt_ff == 4'h0) begin
            if (ph_ff == SEPC_IGNORE && op_ff == `SEPC_OP_SET_WEL)
                nxt_wel = 1'b1;
            if (ph_ff == SEPC_IGNORE && op_ff == `SEPC_OP_CLR_WEL)
                nxt_wel = 1'b0;
            if (op_ff == `SEPC_OP_WR_STAT && ndat_ff != 6'h00 && wel_ff
                && !sabort_ff && !(ppe_ff && !wp_n_s)) begin
                nxt_busy = 1'b1; nxt_wmem = 1'b0; nxt_tmr = 32'h0;
            end
            if (op_ff == `SEPC_OP_WR_MEM && ph_ff == SEPC_DATA &&
                ndat_ff != 6'h00 && wel_ff) begin
                nxt_busy = 1'b1; nxt_wmem = 1'b1; nxt_tmr = 32'h0;
                nxt_cidx = 6'h00;
            end
            nxt_op = 8'h00;
        end
        if (cs_rise) nxt_ph = SEPC_IGNORE;
        // self-timed write cycle
        if (busy_ff) begin
            nxt_tmr = tmr_ff + 32'h1;
            if (!cidx_ff[5]) nxt_cidx = cidx_ff + 6'h01;
            if (tmr_ff == 32'(TWC_CYC - 1)) begin
                nxt_busy = 1'b0; nxt_wel = 1'b0;
                if (!wmem_ff) begin
                    nxt_ppe = sd_ff[`SEPC_SR_PPE];
                    nxt_bg = {sd_ff[`SEPC_SR_BG_HI], sd_ff[`SEPC_SR_BG_LO]};
                end
            end
        end
    end

    // register the state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sck_d_ff <= 1'b0; cs_d_ff <= 1'b1; hold_ff <= 1'b0;
            hold_d_ff <= 1'b0;
            ph_ff <= SEPC_IGNORE; sh_ff <= 8'h00; op_ff <= 8'h00;
            bcnt_ff <= 4'h0; acnt_ff <= 5'h00; adr_ff <= 16'h0000;
            pval_ff <= 32'h0000_0000; ndat_ff <= 6'h00;
            wel_ff <= 1'b0; ppe_ff <= 1'b0; bg_ff <= 2'b00;
            sd_ff <= 8'h00; sabort_ff <= 1'b0; busy_ff <= 1'b0;
            wmem_ff <= 1'b0; tmr_ff <= 32'h0000_0000; cidx_ff <= 6'h20;
            osh_ff <= 8'h00; so_ff <= 1'b0; oe_ff <= 1'b0;
        end else begin
            sck_d_ff <= sck_s; cs_d_ff <= cs_n_s; hold_ff <= nxt_hold;
            hold_d_ff <= hold_ff;
            ph_ff <= nxt_ph; sh_ff <= nxt_sh; op_ff <= nxt_op;
            bcnt_ff <= nxt_bcnt; acnt_ff <= nxt_acnt; adr_ff <= nxt_adr;
            pval_ff <= nxt_pval; ndat_ff <= nxt_ndat;
            wel_ff <= nxt_wel; ppe_ff <= nxt_ppe; bg_ff <= nxt_bg;
            sd_ff <= nxt_sd; sabort_ff <= nxt_sabort; busy_ff <= nxt_busy;
            wmem_ff <= nxt_wmem; tmr_ff <= nxt_tmr; cidx_ff <= nxt_cidx;
            osh_ff <= nxt_osh; so_ff <= nxt_so; oe_ff <= nxt_oe;
        end
    end

    assign serial_out_o    = so_ff;
    assign serial_out_oe_o = oe_ff;
    assign busy_o          = busy_ff;

    // checks; the guard limits are rebuilt from the mask, not the function
    sequence wr_start_s;
        $rose(busy_ff);
    endsequence
    busy_holds_a: assert property (wr_start_s |=> busy_ff [*8])
        else $error("busy dropped early");
    wel_clear_a: assert property ($fell(busy_ff) |-> !wel_ff)
        else $error("latch kept after write");
    oe_desel_a: assert property (cs_n_s |=> !oe_ff)
        else $error("output driven while deselected");
    oe_pause_a: assert property (hold_ff |=> !oe_ff)
        else $error("output driven while paused");
    busy_start_a: assert property (wr_start_s |-> $past(cs_rise))
        else $error("write not at select rise");
    stat_zero_a: assert property (stat[6:4] == 3'b000)
        else $error("reserved status bits set");
    so_change_a: assert property (
        !$past(sck_fall) && !cs_n_s |-> $stable(so_ff))
        else $error("output moved off fall");
    wel_needed_a: assert property (wr_start_s |-> $past(wel_ff))
        else $error("write without latch");
    guard_block_a: assert property (
        mif.we |-> bg_ff == 2'b00
        || (bg_ff == 2'b01 && mif.waddr < amask - (amask >> 2))
        || (bg_ff == 2'b10 && mif.waddr < amask - (amask >> 1)))
        else $error("guarded byte written");
endmodule
`default_nettype wire

// >>> sim/sepc_host.sv
/*
 * host serial controller model: drives clock, select, data and pause.
 * assumes clk_i runs at 5 ns; the serial clock is built from it.
 */
`timescale 1ns/1ps
`default_nettype none
module sepc_host (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      sel_n_o,
    output logic      mosi_o,
    output logic      pause_n_o
);
    localparam int HALF = 8; // 80 ns serial clock period
    logic cpol;
    // idle: clock still, select high
    initial begin
        cpol = 1'b0;
        sck_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
        pause_n_o = 1'b1;
    end
    // all changes land 1 ns after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // clock settles at its idle level first, so no false edge at the fall
    task automatic open_f();
        sck_o = cpol;
        tick(HALF);
        sel_n_o = 1'b0;
        tick(HALF);
    endtask
    // msb first; data set while low, reply taken just before the rise
    task automatic xfer(input logic [7:0] tx, input int nb,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            sck_o = 1'b0;
            mosi_o = tx[i];
            tick(HALF);
            rx = {rx[6:0], miso_i};
            sck_o = 1'b1;
            tick(HALF);
        end
    endtask
    // clock returns to its idle level before select rises; released data line shows junk
    task automatic close_f();
        sck_o = cpol;
        tick(HALF);
        sel_n_o = 1'b1;
        mosi_o = ~mosi_o;
        tick(HALF);
    endtask
    // pause and resume only with the clock low
    task automatic pause(input logic on);
        sck_o = 1'b0;
        tick(HALF);
        pause_n_o = ~on;
        tick(HALF);
    endtask
endmodule
`default_nettype wire

// >>> sim/sepc_top_tb.sv
/*
 * self-checking bench of the eeprom command block with a host model.
 * assumes design files and sepc_host are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module sepc_top_tb;
    localparam int TWC   = 1000;   // shortened write cycle
    localparam int LIMIT = 100000; // run ceiling in clocks
    logic        clk_i, sys_rst_i, write_protect_n_i;
    logic        sck, sel_n, mosi, pause_n, so, so_oe, busy_o, miso;
    logic [7:0]  mem_m [0:2047];
    logic [7:0]  sr, rx;
    logic [7:0]  q [$];
    logic [31:0] lfsr, r;
    int          n_mismatch, compares, guard_m;
    int          cyc = 0;
    logic [7:0]  bad [4] = '{8'hff, 8'h00, 8'h07, 8'h86};
    logic [15:0] ga [5] = '{16'h03ff, 16'h0400, 16'h05ff, 16'h0600,
                            16'h07ff};
    logic [15:0] wa [4] = '{16'h021e, 16'h021f, 16'h0200, 16'h0201};
    // no pull on the line: an undriven pin reads back as the inverse
    assign miso = so_oe ? so : ~so;
    sepc_host host (
        .clk_i     (clk_i),
        .miso_i    (miso),
        .sck_o     (sck),
        .sel_n_o   (sel_n),
        .mosi_o    (mosi),
        .pause_n_o (pause_n)
    );
    sepc_top #(.TWC_CYC(TWC), .BIG_ARR(1'b1)) u_dut (
        .clk_i             (clk_i),
        .sys_rst_i         (sys_rst_i),
        .spi_clock_i       (sck),
        .select_n_i        (sel_n),
        .serial_in_i       (mosi),
        .pause_n_i         (pause_n),
        .write_protect_n_i (write_protect_n_i),
        .serial_out_o      (so),
        .serial_out_oe_o   (so_oe),
        .busy_o            (busy_o)
    );
    // 200 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic stop_test();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // guarded range of the 16-kbit map
    function automatic logic prot(input int a);
        case (guard_m)
            1: return a >= 11'h600;
            2: return a >= 11'h400;
            3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic cmd(input logic [7:0] op);
        host.open_f();
        host.xfer(op, 8, rx);
        host.close_f();
    endtask
    task automatic rd_sts(output logic [7:0] s);
        host.open_f();
        host.xfer(8'h05, 8, rx);
        host.xfer(8'h00, 8, s);
        host.close_f();
    endtask
    task automatic op_addr(input logic [7:0] op, input logic [15:0] a);
        host.open_f();
        host.xfer(op, 8, rx);
        host.xfer(a[15:8], 8, rx);
        host.xfer(a[7:0], 8, rx);
    endtask
    // page write; model keeps the page bits and wraps the offset
    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d[$],
                          input logic en);
        int b;
        b = int'(a[10:0]);
        op_addr(8'h02, a);
        foreach (d[i]) begin
            host.xfer(d[i], 8, rx);
            if (en && !prot(b))
                mem_m[(b & 11'h7e0) | ((b + i) & 5'h1f)] = d[i];
        end
        host.close_f();
    endtask
    task automatic rd_mem(input logic [15:0] a);
        op_addr(8'h03, a);
        host.xfer(8'h00, 8, rx);
        host.close_f();
        check(rx, mem_m[a[10:0]]);
    endtask
    // bounded wait for the end of a write cycle
    task automatic wait_idle();
        int n;
        n = 0;
        host.tick(8);
        while (busy_o !== 1'b0 && n < TWC + 50) begin
            host.tick(1);
            n++;
        end
        check({7'h00, busy_o}, 8'h00);
    endtask
    task automatic sts_frame(input logic [7:0] d, input logic drop);
        host.open_f();
        host.xfer(8'h01, 8, rx);
        host.xfer(d, 8, rx);
        if (drop)
            write_protect_n_i = 1'b0;
        host.close_f();
    endtask
    // latch, status write, wait, read back
    task automatic sw(input logic [7:0] d, input logic drop);
        cmd(8'h06);
        sts_frame(d, drop);
        wait_idle();
        rd_sts(sr);
    endtask
    // pause with the data line toggling; output must float meanwhile
    task automatic hold();
        host.pause(1'b1);
        repeat (6) begin
            r = rnd();
            host.mosi_o = r[0];
            host.tick(1);
        end
        check({7'h00, so_oe}, 8'h00);
        host.pause(1'b0);
    endtask
    initial begin
        sys_rst_i = 1'b1;
        write_protect_n_i = 1'b1;
        n_mismatch = 0;
        compares = 0;
        guard_m = 0;
        lfsr = 32'h0000_edc5;
        repeat (3) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        host.tick(3);
        check({6'h00, busy_o, so_oe}, 8'h00);
        rd_sts(sr);
        check(sr, 8'h00);
        cmd(8'h06);
        rd_sts(sr);
        check(sr, 8'h02);
        // unknown codes: no reply, no state change
        foreach (bad[i]) begin
            host.open_f();
            host.xfer(bad[i], 8, rx);
            host.xfer(8'h00, 8, rx);
            check({7'h00, so_oe}, 8'h00);
            host.close_f();
        end
        host.cpol = 1'b1;
        rd_sts(sr);
        check(sr, 8'h02);
        host.cpol = 1'b0;
        // partial data byte before select rise starts nothing
        op_addr(8'h02, 16'h0010);
        host.xfer(8'h55, 5, rx);
        host.close_f();
        host.tick(8);
        check({7'h00, busy_o}, 8'h00);
        rd_sts(sr);
        check(sr, 8'h02);
        // byte write with junk in the unused address bits
        q = {8'ha7};
        wr_mem(16'hf805, q, 1'b1);
        host.tick(8);
        check({7'h00, busy_o}, 8'h01);
        rd_sts(sr);
        check(sr, 8'h03);
        sts_frame(8'h8c, 1'b0);
        wait_idle();
        rd_sts(sr);
        check(sr, 8'h00);
        rd_mem(16'h0005);
        q = {8'h3c};
        wr_mem(16'h0005, q, 1'b0);
        wait_idle();
        rd_mem(16'h0005);
        // page load past the page end wraps to its start
        cmd(8'h06);
        q = {8'h11, 8'h22, 8'h33, 8'h44};
        wr_mem(16'h021e, q, 1'b1);
        wait_idle();
        foreach (wa[i])
            rd_mem(wa[i]);
        foreach (ga[i]) begin
            cmd(8'h06);
            q = {ga[i][7:0] ^ 8'ha5};
            wr_mem(ga[i], q, 1'b1);
            wait_idle();
        end
        // paused status read: input ignored, output floats
        cmd(8'h06);
        host.open_f();
        host.xfer(8'h00, 4, rx);
        hold();
        host.xfer(8'h50, 4, rx);
        host.xfer(8'h00, 4, rx);
        sr = rx;
        hold();
        host.xfer(8'h00, 4, rx);
        host.close_f();
        check({sr[3:0], rx[3:0]}, 8'h02);
        sw(8'hff, 1'b0);
        check(sr, 8'h8c);
        write_protect_n_i = 1'b0;
        sw(8'h00, 1'b0);
        check(sr & 8'hfd, 8'h8c);
        write_protect_n_i = 1'b1;
        sw(8'h00, 1'b1);
        write_protect_n_i = 1'b1;
        check(sr & 8'hfd, 8'h8c);
        sw(8'h00, 1'b0);
        check(sr, 8'h00);
        // pin low is ignored while the enable bit is clear
        write_protect_n_i = 1'b0;
        for (int g = 1; g < 4; g++) begin
            sw(8'(g << 2), 1'b0);
            check(sr, 8'(g << 2));
            guard_m = g;
            foreach (ga[i]) begin
                cmd(8'h06);
                r = rnd();
                q = {r[7:0]};
                wr_mem(ga[i], q, 1'b1);
                wait_idle();
                rd_mem(ga[i]);
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
